// File: adc_window_cfg.svh
// constants for the converter result window detector
`ifndef ADC_WINDOW_CFG_SVH
`define ADC_WINDOW_CFG_SVH
`define RESULT_WIDTH       8
`define CONV_SAR_CLOCKS    8
`define TRACK_TIME_NS      300
`define CORE_CLK_PERIOD_NS 10
`define SAR_DIV_RESET      5'h03
`define SAR_DIV_WIDTH      5
`define LIMIT_RESET        8'h00
`define SIGN_BIT           7
`define CODE_MIN           8'h00
`endif

// File: adc_window_pkg.sv
// types shared by the window detector files
package adc_window_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_TRACK = 2'b01,
    ST_CONV  = 2'b10
  } conv_state_type;
endpackage

// File: window_compare.sv
// window comparison of one result against two limits
`timescale 1ns/10ps
module window_compare #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] result_in,
  input  wire logic [WIDTH-1:0] upper_in,
  input  wire logic [WIDTH-1:0] lower_in,
  input  wire logic             signed_in,
  output logic                  match_out
);
  if (WIDTH < 2) begin : g_bad_width
    $error("width too small");
  end
  // flipping the sign bit turns signed order into unsigned order
  wire [WIDTH-1:0] flip = signed_in ? {1'b1, {(WIDTH-1){1'b0}}} : '0;
  wire [WIDTH-1:0] r_k  = result_in ^ flip;
  wire [WIDTH-1:0] u_k  = upper_in ^ flip;
  wire [WIDTH-1:0] l_k  = lower_in ^ flip;
  wire above_upper = r_k > u_k;
  wire below_lower = r_k < l_k;
  wire inside_mode = l_k > u_k;
  // inside: upper < result < lower; outside: result < lower or > upper
  assign match_out = inside_mode ? (above_upper && below_lower)
                                 : (above_upper || below_lower);
endmodule

// File: adc_result_window_detector.sv
// result formatting and window detection for the 8-bit converter
// Function
// - compare each new result, raise window flag
// - single-ended results are unsigned 0x00 to 0xff
// - differential results are two's complement, max 0x7f
// - inside window: flag strictly between limits
// - outside window: flag strictly beyond limits
// - differential limits compared as signed values
// - window flag readable for polling
// - conversion lasts at least eight sar clocks
// - track at least 300 ns before converting
`timescale 1ns/10ps
`include "adc_window_cfg.svh"
module adc_result_window_detector #(
  parameter int WIDTH     = `RESULT_WIDTH,
  parameter int SAR_BITS  = `CONV_SAR_CLOCKS
) (
  input  wire logic             core_clk_in,
  input  wire logic             reset_n_in,
  input  wire logic             clk_en_in,
  input  wire logic             enable_in,
  input  wire logic             start_in,
  input  wire logic             differential_in,
  input  wire logic [4:0]       sar_div_in,
  input  wire logic [WIDTH-1:0] window_upper_limit_in,
  input  wire logic [WIDTH-1:0] window_lower_threshold_in,
  input  wire logic             comparator_in,
  input  wire logic             flag_clear_in,
  output logic                  track_out,
  output logic [WIDTH-1:0]      sar_trial_out,
  output logic                  busy_out,
  output logic [WIDTH-1:0]      conversion_result_out,
  output logic                  result_valid_out,
  output logic                  window_match_flag_out
);
  localparam int TRACK_CYC =
    (`TRACK_TIME_NS + `CORE_CLK_PERIOD_NS - 1) / `CORE_CLK_PERIOD_NS;
  localparam int CW = $clog2(TRACK_CYC + 1);
  localparam int BW = (SAR_BITS > 1) ? $clog2(SAR_BITS) : 1;
  localparam logic [WIDTH-1:0] MSB_ONLY = {1'b1, {(WIDTH-1){1'b0}}};

  // sizes the sar sequencing cannot serve are refused at elaboration
  if (WIDTH < 2) begin : g_bad_width
    $error("result narrower than two bits");
  end
  if (WIDTH != SAR_BITS) begin : g_bad_bits
    $error("one sar clock per bit expected");
  end
  if (SAR_BITS < `CONV_SAR_CLOCKS) begin : g_bad_len
    $error("too few sar clocks");
  end
  if (TRACK_CYC < 1) begin : g_bad_track
    $error("tracking time below one core cycle");
  end

  adc_window_pkg::conv_state_type state_q, state_d;
  logic [1:0]       cmp_sync_q;
  logic [`SAR_DIV_WIDTH-1:0] div_q;
  logic [CW-1:0]    track_q;
  logic [BW-1:0]    bit_q;
  logic [WIDTH-1:0] trial_q, res_q;
  logic             valid_q, flag_q, diff_q;
  logic             match;
  wire  [WIDTH-1:0] onehot;
  wire  [WIDTH-1:0] kept;
  wire  [WIDTH-1:0] next_trial;

  // comparator comes from the analog side, so it is synchronised
  // only the second stage is read; the first may still settle
  wire cmp_bit   = cmp_sync_q[1];
  wire sar_tick  = (div_q == '0);
  wire track_done = (track_q == CW'(TRACK_CYC));
  wire last_bit  = (bit_q == BW'(SAR_BITS - 1));
  wire conv_done = (state_q == adc_window_pkg::ST_CONV) && sar_tick
                   && last_bit;
  // decodes shared by the sequencer and the result registers
  wire start_take = (state_q == adc_window_pkg::ST_IDLE) && enable_in
                    && start_in;
  wire flag_set  = conv_done && match;

  // one slice per result bit: the bit under test takes the comparator,
  // the next lower bit becomes the new trial
  for (genvar i = 0; i < WIDTH; i++) begin : g_sar_bit
    assign onehot[i] = (bit_q == BW'(WIDTH - 1 - i));
    assign kept[i]   = onehot[i] ? (cmp_bit & trial_q[i]) : trial_q[i];
    if (i == WIDTH - 1) begin : g_top
      assign next_trial[i] = kept[i];
    end else begin : g_low
      assign next_trial[i] = kept[i] | onehot[i+1];
    end
  end

  // differential code from the sar is offset binary; flip msb
  // mode comes from diff_q so a pin change mid-run cannot split it
  wire [WIDTH-1:0] fmt_code = diff_q ?
                              {~kept[WIDTH-1], kept[WIDTH-2:0]} : kept;

  // limits are read live; software changes them only while idle
  window_compare #(.WIDTH(WIDTH)) u_cmp (
    .result_in (fmt_code),
    .upper_in  (window_upper_limit_in),
    .lower_in  (window_lower_threshold_in),
    .signed_in (diff_q),
    .match_out (match)
  );

  always_comb begin
    state_d = state_q;
    case (state_q)
      adc_window_pkg::ST_IDLE:
        if (start_take) state_d = adc_window_pkg::ST_TRACK;
      adc_window_pkg::ST_TRACK:
        if (track_done && sar_tick) state_d = adc_window_pkg::ST_CONV;
      adc_window_pkg::ST_CONV:
        if (conv_done) state_d = adc_window_pkg::ST_IDLE;
      default: state_d = adc_window_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmp_sync_q <= 2'b00;
    end else if (clk_en_in) begin
      cmp_sync_q <= {cmp_sync_q[0], comparator_in};
    end
  end

  // divider from core clock; the ratio is software's to choose
  // tick spacing must exceed the two-stage synchroniser delay
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      div_q <= '0;
    end else if (clk_en_in) begin
      div_q <= sar_tick ? sar_div_in : div_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= adc_window_pkg::ST_IDLE;
    end else if (clk_en_in) begin
      // enable low aborts: no result unless on the last sar tick, old result and flag are kept
      state_q <= enable_in ? state_d : adc_window_pkg::ST_IDLE;
    end
  end

  // tracking time counted in core cycles, held once reached
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      track_q <= '0;
    end else if (clk_en_in) begin
      if (state_q != adc_window_pkg::ST_TRACK) track_q <= '0;
      else if (!track_done) track_q <= track_q + 1'b1;
    end
  end

  // one result bit resolved per sar clock
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bit_q <= '0;
    end else if (clk_en_in) begin
      if (state_q != adc_window_pkg::ST_CONV) bit_q <= '0;
      else if (sar_tick) bit_q <= bit_q + 1'b1;
    end
  end

  // trial code starts at mid scale and halves its step each tick
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      trial_q <= '0;
    end else if (clk_en_in) begin
      if (state_q != adc_window_pkg::ST_CONV) trial_q <= MSB_ONLY;
      else if (sar_tick) trial_q <= next_trial;
    end
  end

  // mode captured when a start is taken, held through the conversion
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      diff_q <= 1'b0;
    end else if (clk_en_in) begin
      if (start_take) diff_q <= differential_in;
    end
  end

  // result and flag written in the same cycle
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      valid_q <= 1'b0;
    end else if (clk_en_in) begin
      valid_q <= conv_done;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      res_q <= WIDTH'(`CODE_MIN);
    end else if (clk_en_in) begin
      if (conv_done) res_q <= fmt_code;
    end
  end

  // a new match beats a clear in the same cycle
  // clearing is the only way down, so a missed event stays visible
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flag_q <= 1'b0;
    end else if (clk_en_in) begin
      if (flag_set) flag_q <= 1'b1;
      else if (flag_clear_in) flag_q <= 1'b0;
    end
  end

  // track and busy outputs decode the state register directly; the others drive registers out
  assign track_out             = (state_q == adc_window_pkg::ST_TRACK);
  assign busy_out              = (state_q != adc_window_pkg::ST_IDLE);
  assign sar_trial_out         = trial_q;
  assign conversion_result_out = res_q;
  assign result_valid_out      = valid_q;
  assign window_match_flag_out = flag_q;
endmodule

// File: adc_window_checker.sv
// assertions on the window detector ports
`timescale 1ns/10ps
module adc_window_checker #(
  parameter int WIDTH = 8
) (
  input wire logic             core_clk_in,
  input wire logic             reset_n_in,
  input wire logic             flag_clear_in,
  input wire logic             track_out,
  input wire logic             busy_out,
  input wire logic [WIDTH-1:0] conversion_result_out,
  input wire logic             result_valid_out,
  input wire logic             window_match_flag_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_VALID_PULSE: assert property (
    result_valid_out |=> !result_valid_out) else $error("long valid");
  AST_RESULT_HOLD: assert property (
    !result_valid_out |-> $stable(conversion_result_out))
    else $error("result moved without valid");
  AST_FLAG_WITH_VALID: assert property (
    $rose(window_match_flag_out) |-> result_valid_out)
    else $error("flag rose without result");
  AST_CONV_LEN: assert property (
    $fell(track_out) && busy_out |-> !result_valid_out [*8])
    else $error("too short");
  AST_TRACK_FIRST: assert property (
    $rose(busy_out) |-> track_out) else $error("no tracking");
  AST_TRACK_LEN: assert property (
    $rose(track_out) |-> ##29 track_out) else $error("tracking cut short");
  AST_FLAG_STICKY: assert property (
    window_match_flag_out && !flag_clear_in |=> window_match_flag_out)
    else $error("flag lost");
  AST_FLAG_CLEAR: assert property (
    flag_clear_in |=> !window_match_flag_out || result_valid_out)
    else $error("flag not cleared");
  cover property (result_valid_out && window_match_flag_out);
  cover property (result_valid_out && !window_match_flag_out);
  // abort: busy drops with no result
  cover property ($fell(busy_out) && !result_valid_out);
endmodule
bind adc_result_window_detector adc_window_checker #(.WIDTH(WIDTH)) chk (
  .core_clk_in           (core_clk_in),
  .reset_n_in            (reset_n_in),
  .flag_clear_in         (flag_clear_in),
  .track_out             (track_out),
  .busy_out              (busy_out),
  .conversion_result_out (conversion_result_out),
  .result_valid_out      (result_valid_out),
  .window_match_flag_out (window_match_flag_out)
);

// File: tb_adc_result_window_detector.sv
// self-checking bench for the window detector
`timescale 1ns/10ps
module tb_adc_result_window_detector;
  logic       clk = 0, rst_n = 0, en = 0, start = 0, diff = 0, clr = 0;
  logic       cmp = 0, busy, vld, flag, trk;
  logic [7:0] up = 0, lo = 0, code = 0, trial, res;
  int         fails = 0, cmp_count = 0;
  logic [7:0] tbl [2][8] = '{'{8'h00, 8'h0f, 8'h10, 8'h11, 8'h1f, 8'h20,
    8'h21, 8'hff}, '{8'h80, 8'hfe, 8'hff, 8'h00, 8'h0f, 8'h10, 8'h11, 8'h7f}};
  adc_result_window_detector dut (.core_clk_in(clk), .reset_n_in(rst_n),
    .clk_en_in(1'b1), .enable_in(en), .start_in(start),
    .differential_in(diff), .window_upper_limit_in(up),
    .sar_div_in(5'h10), // tick every 17 cycles, below 6 mhz
    .window_lower_threshold_in(lo), .comparator_in(cmp),
    .flag_clear_in(clr), .track_out(trk), .sar_trial_out(trial),
    .busy_out(busy), .conversion_result_out(res), .result_valid_out(vld),
    .window_match_flag_out(flag));
  initial forever #5 clk = ~clk;
  // analog side: differential code is offset binary with msb flipped
  always @(negedge clk) cmp <= ((diff ? code ^ 8'h80 : code) >= trial);
  function automatic logic win(logic [7:0] v, u, l, logic s);
    logic signed [8:0] a, b, c;
    a = {s & v[7], v};
    b = {s & u[7], u};
    c = {s & l[7], l};
    return (c > b) ? (a > b && a < c) : (a > b || a < c);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic kick(input logic [7:0] v, input logic c);
    @(negedge clk) code = v; clr = c;
    @(negedge clk) clr = 0; start = 1;
    @(negedge clk) start = 0;
  endtask
  task automatic conv(input logic [7:0] v);
    int n;
    int t;
    n = 0;
    t = 0;
    kick(v, 1'b1);
    while (vld !== 1'b1 && n < 400) begin
      @(negedge clk);
      if (trk === 1'b1) t++;
      n++;
    end
    chk({7'h0, vld}, 8'h01);
    chk(res, v);
    chk({7'h0, flag}, {7'h0, win(v, up, lo, diff)});
    chk({7'h0, t >= 30}, 8'h01); // 300 ns at 10 ns a cycle
  endtask
  task automatic sweep(input logic d, input logic [7:0] u, l);
    diff = d;
    up = u;
    lo = l;
    for (int i = 0; i < 8; i++) conv(tbl[d][i]);
  endtask
  task automatic se_window();
    sweep(1'b0, 8'h10, 8'h20);
    sweep(1'b0, 8'h20, 8'h10);
  endtask
  task automatic diff_window();
    sweep(1'b1, 8'hff, 8'h10);
    sweep(1'b1, 8'h10, 8'hff);
  endtask
  // abort keeps old result; flag stays set with no clear
  task automatic abort_mid();
    sweep(1'b0, 8'h20, 8'h10);
    kick(8'h15, 1'b0);
    repeat (60) @(negedge clk);
    en = 0;
    repeat (2) @(negedge clk);
    chk({7'h0, busy}, 8'h00);
    chk(res, 8'hff);
    chk({7'h0, flag}, 8'h01);
    en = 1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    en = 1;
    se_window();
    diff_window();
    abort_mid();
    wrap_up();
  end
endmodule
